// ===== ebc_pkg.sv
// Operation
// - Register match breaks when unmasked fields equal
// - Register cancel command disarms register match
// - Comparison never stalls the running CPU
// - Register match index values span 12 bits
// - Compound break joins PC, memory, registers
// - Compound fires only when all parts match
// - Arming compound cancels address, data, register
// - Arming other classes cancels compound condition
// - Compound cancel command disarms compound condition
// - One compound condition, new replaces old
// - Every compound field has its own mask
// - Compound evaluated only on data memory access
// - Memory access needed even if fully masked
// - Compound index values span 12 bits
// - Clear all disarms conditions, keeps break mode
package ebc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD      = 8'h00; // Command strobes, write only
    localparam logic [7:0] OFS_ARMED    = 8'h04; // Armed classes, read only
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08; // Sticky break events, write one to clear
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c; // Interrupt enables
    localparam logic [7:0] OFS_RM_REG   = 8'h10; // Register match accumulators and flags
    localparam logic [7:0] OFS_RM_X     = 8'h14; // Register match first index value
    localparam logic [7:0] OFS_RM_Y     = 8'h18; // Register match second index value
    localparam logic [7:0] OFS_RM_MASK  = 8'h1c; // Register match masks
    localparam logic [7:0] OFS_CM_PC    = 8'h20; // Compound program counter
    localparam logic [7:0] OFS_CM_MEM   = 8'h24; // Compound memory address, data, direction
    localparam logic [7:0] OFS_CM_REG   = 8'h28; // Compound accumulators and flags
    localparam logic [7:0] OFS_CM_X     = 8'h2c; // Compound first index value
    localparam logic [7:0] OFS_CM_Y     = 8'h30; // Compound second index value
    localparam logic [7:0] OFS_CM_MASK  = 8'h34; // Compound masks
    localparam logic [7:0] OFS_MODE     = 8'h38; // Break mode, untouched by clear all

    // ------------------------------------------------------------
    // Command bit positions
    // ------------------------------------------------------------
    localparam int CMD_ARM_RM   = 0; // Arm register_match_break
    localparam int CMD_RM_CAN   = 1; // register_break_cancel
    localparam int CMD_ARM_CM   = 2; // Arm compound_break
    localparam int CMD_CM_CAN   = 3; // compound_break_cancel
    localparam int CMD_CLR_ALL  = 4; // clear_all_breaks
    localparam int CMD_ARM_ADR  = 5; // Arm address-only break
    localparam int CMD_ARM_DAT  = 6; // Arm data_only_break

    // ------------------------------------------------------------
    // Armed and event bit positions
    // ------------------------------------------------------------
    localparam int ARM_ADR = 0; // Address-only class
    localparam int ARM_DAT = 1; // Data-only class
    localparam int ARM_RM  = 2; // Register match class
    localparam int ARM_CM  = 3; // Compound class
    localparam int EV_RM   = 0; // Register match break event
    localparam int EV_CM   = 1; // Compound break event

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int REG_A_LSB  = 0;  // Accumulator A
    localparam int REG_B_LSB  = 4;  // Accumulator B
    localparam int REG_F_LSB  = 8;  // Flags: carry, zero, decimal, interrupt
    localparam int MEM_D_LSB  = 12; // Memory data nibble
    localparam int MEM_WR_BIT = 16; // Memory direction, one is write
    localparam int MSK_PC     = 0;  // Compound mask: program counter
    localparam int MSK_ADDR   = 1;  // Compound mask: memory address
    localparam int MSK_DATA   = 2;  // Compound mask: memory data
    localparam int MSK_RW     = 3;  // Compound mask: direction
    localparam int MSK_REG    = 4;  // Register mask field lsb in the compound mask register
    localparam int MODE_EN    = 0;  // Break enable

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  RST_ARMED = 4'h0;  // Nothing armed
    localparam logic [7:0]  RST_MASK8 = 8'hff; // All register fields masked
    localparam logic [3:0]  RST_MSK4  = 4'hf;  // All access fields masked
    localparam logic [0:0]  RST_MODE  = 1'h1;  // Breaks enabled
    localparam logic [1:0]  HSIZE_W   = 2'h2;  // Word transfer

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  a;     // Accumulator A
        logic [3:0]  b;     // Accumulator B
        logic [3:0]  flags; // {interrupt_flag, decimal_flag, zero_flag, carry_flag}
        logic [11:0] x;     // First index register
        logic [11:0] y;     // Second index register
    } ebc_regset_t;

    typedef struct packed {
        logic        a;
        logic        b;
        logic [3:0]  flags; // One mask bit per flag
        logic        x;
        logic        y;
    } ebc_regmask_t;

    typedef struct packed {
        logic        instr_end; // Last cycle of an instruction
        logic [11:0] pc;        // Address of that instruction
        logic        mem_acc;   // Instruction touches data memory
        logic        mem_wr;    // Access is a write
        logic [11:0] mem_addr;  // Data memory address
        logic [3:0]  mem_data;  // Nibble read or written
        ebc_regset_t regs;      // Register file after the instruction
    } ebc_cpu_obs_t;

endpackage : ebc_pkg

// ===== ebc_regcmp.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Masked register-set comparator, purely combinational
// ------------------------------------------------------------
module ebc_regcmp
(
    input  wire ebc_pkg::ebc_regset_t  obs,   // Live CPU registers
    input  wire ebc_pkg::ebc_regset_t  ref_v, // Programmed values
    input  wire ebc_pkg::ebc_regmask_t msk,   // One masks a field out
    output logic                       hit    // All unmasked fields equal
);

    // Per-flag compare, masked flags always agree
    logic [3:0] flag_ok;

    // ------------------------------------------------------------
    // Flag compare, one lane per flag
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_flag
            assign flag_ok[g] = msk.flags[g] | (obs.flags[g] == ref_v.flags[g]);
        end
    endgenerate

    // Full twelve-bit index compares, no model-size clipping
    assign hit = (msk.a | (obs.a == ref_v.a))
               & (msk.b | (obs.b == ref_v.b))
               & (&flag_ok)
               & (msk.x | (obs.x == ref_v.x))
               & (msk.y | (obs.y == ref_v.y));

endmodule : ebc_regcmp

// ===== ebc_break.sv
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ebc_break
(
    input  wire logic                  hclk,      // Bus and CPU clock
    input  wire logic                  hresetn,   // Asynchronous reset, active low
    input  wire logic                  hsel,      // Slave select
    input  wire logic [7:0]            haddr,     // Byte address
    input  wire logic [1:0]            htrans,    // Transfer type
    input  wire logic                  hwrite,    // Write when high
    input  wire logic [2:0]            hsize,     // Transfer size
    input  wire logic [31:0]           hwdata,    // Write data
    input  wire logic                  hready,    // Bus ready
    output logic                       hreadyout, // Slave ready
    output logic                       hresp,     // Always OKAY
    output logic [31:0]                hrdata,    // Read data
    input  wire ebc_pkg::ebc_cpu_obs_t cpu_obs,   // Observed CPU, same clock
    output logic                       halt_req,  // One-cycle halt request
    output logic [3:0]                 armed,     // Armed classes
    output logic                       irq        // Level interrupt
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                 hreadyout_ff; // Low during the read wait state
    logic [31:0]          hrdata_ff;    // Registered read data
    logic                 wr_pend_ff;   // Write data phase pending
    logic                 rd_pend_ff;   // Read wait state pending
    logic [7:0]           addr_ff;      // Latched address
    logic [3:0]           armed_ff;     // Armed classes
    logic [3:0]           nxt_armed;    // Next armed classes
    logic [1:0]           stat_ff;      // Sticky events
    logic [1:0]           nxt_stat;     // Next sticky events
    logic [1:0]           mask_ff;      // Interrupt enables
    logic                 irq_ff;       // Registered interrupt
    logic                 halt_ff;      // Registered halt request
    logic [0:0]           mode_ff;      // Break mode
    ebc_pkg::ebc_regset_t rm_val_ff;    // Register match values
    ebc_pkg::ebc_regmask_t rm_msk_ff;   // Register match masks
    ebc_pkg::ebc_regset_t cm_val_ff;    // Compound register values
    ebc_pkg::ebc_regmask_t cm_msk_ff;   // Compound register masks
    logic [11:0]          cm_pc_ff;     // Compound program counter
    logic [11:0]          cm_addr_ff;   // Compound memory address
    logic [3:0]           cm_data_ff;   // Compound memory data
    logic                 cm_wr_ff;     // Compound direction
    logic [3:0]           cm_amsk_ff;   // Compound access masks
    logic                 addr_ph;      // Address phase accepted
    logic                 wr_go;        // Write lands this cycle
    logic                 rm_hit;       // Register match comparator
    logic                 cm_reg_hit;   // Compound register part
    logic                 cm_acc_hit;   // Compound memory part
    logic                 cm_pc_hit;    // Compound program counter part
    logic [1:0]           ev;           // Break events this cycle
    logic [31:0]          rd_val;       // Read mux

    // Address decode for the write paths; the read mux decodes addr_ff itself
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
        is_reg = (a == ofs);
    endfunction : is_reg

    // ------------------------------------------------------------
    // AHB-Lite front end
    // ------------------------------------------------------------
    assign addr_ph = hsel & hready & htrans[1];
    assign wr_go   = wr_pend_ff;

    // Address phase capture; reads get one wait state so a write
    // in the previous data phase is always visible to the read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_ff      <= 8'h00;
            wr_pend_ff   <= 1'b0;
            rd_pend_ff   <= 1'b0;
            hreadyout_ff <= 1'b1;
        end
        else
        begin
            rd_pend_ff <= 1'b0;
            if (rd_pend_ff)
            begin
                hreadyout_ff <= 1'b1; // Read data ready next edge
            end
            if (addr_ph)
            begin
                addr_ff    <= {haddr[7:2], 2'b00};
                // Only word writes are taken; others are ignored
                wr_pend_ff <= hwrite & (hsize[1:0] == ebc_pkg::HSIZE_W);
                if (!hwrite)
                begin
                    rd_pend_ff   <= 1'b1;
                    hreadyout_ff <= 1'b0;
                end
            end
            else if (hready)
            begin
                wr_pend_ff <= 1'b0;
            end
        end
    end

    // Read mux, unmapped addresses read as zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (addr_ff)
            ebc_pkg::OFS_ARMED:    rd_val[3:0] = armed_ff;
            ebc_pkg::OFS_IRQ_STAT: rd_val[1:0] = stat_ff;
            ebc_pkg::OFS_IRQ_MASK: rd_val[1:0] = mask_ff;
            ebc_pkg::OFS_RM_REG:   rd_val[11:0] = {rm_val_ff.flags, rm_val_ff.b, rm_val_ff.a};
            ebc_pkg::OFS_RM_X:     rd_val[11:0] = rm_val_ff.x;
            ebc_pkg::OFS_RM_Y:     rd_val[11:0] = rm_val_ff.y;
            ebc_pkg::OFS_RM_MASK:  rd_val[7:0] = {rm_msk_ff.y, rm_msk_ff.x, rm_msk_ff.flags,
                                                 rm_msk_ff.b, rm_msk_ff.a};
            ebc_pkg::OFS_CM_PC:    rd_val[11:0] = cm_pc_ff;
            ebc_pkg::OFS_CM_MEM:   rd_val[16:0] = {cm_wr_ff, cm_data_ff, cm_addr_ff};
            ebc_pkg::OFS_CM_REG:   rd_val[11:0] = {cm_val_ff.flags, cm_val_ff.b, cm_val_ff.a};
            ebc_pkg::OFS_CM_X:     rd_val[11:0] = cm_val_ff.x;
            ebc_pkg::OFS_CM_Y:     rd_val[11:0] = cm_val_ff.y;
            ebc_pkg::OFS_CM_MASK:  rd_val[11:0] = {cm_msk_ff.y, cm_msk_ff.x, cm_msk_ff.flags,
                                                  cm_msk_ff.b, cm_msk_ff.a, cm_amsk_ff};
            ebc_pkg::OFS_MODE:     rd_val[0] = mode_ff[0];
            default:               rd_val = 32'h0000_0000;
        endcase
    end

    // Read data register, loaded in the wait state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_ff <= 32'h0000_0000;
        end
        else if (rd_pend_ff)
        begin
            hrdata_ff <= rd_val;
        end
    end

    // ------------------------------------------------------------
    // Condition registers
    // ------------------------------------------------------------

    // Register match values; full twelve-bit index fields
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rm_val_ff <= '0;
            rm_msk_ff <= ebc_pkg::RST_MASK8;
        end
        else if (wr_go)
        begin
            if (is_reg(addr_ff, ebc_pkg::OFS_RM_REG))
            begin
                rm_val_ff.a     <= hwdata[3:0];
                rm_val_ff.b     <= hwdata[7:4];
                rm_val_ff.flags <= hwdata[11:8];
            end
            if (is_reg(addr_ff, ebc_pkg::OFS_RM_X))
            begin
                rm_val_ff.x <= hwdata[11:0];
            end
            if (is_reg(addr_ff, ebc_pkg::OFS_RM_Y))
            begin
                rm_val_ff.y <= hwdata[11:0];
            end
            if (is_reg(addr_ff, ebc_pkg::OFS_RM_MASK))
            begin
                rm_msk_ff <= {hwdata[0], hwdata[1], hwdata[5:2], hwdata[6], hwdata[7]}; // Struct a on top, bus y on top
            end
        end
    end

    // Compound condition: one set of fields, a write replaces it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cm_val_ff  <= '0;
            cm_msk_ff  <= ebc_pkg::RST_MASK8;
            cm_amsk_ff <= ebc_pkg::RST_MSK4;
            cm_pc_ff   <= 12'h000;
            cm_addr_ff <= 12'h000;
            cm_data_ff <= 4'h0;
            cm_wr_ff   <= 1'b0;
        end
        else if (wr_go)
        begin
            if (is_reg(addr_ff, ebc_pkg::OFS_CM_PC))
            begin
                cm_pc_ff <= hwdata[11:0];
            end
            if (is_reg(addr_ff, ebc_pkg::OFS_CM_MEM))
            begin
                cm_addr_ff <= hwdata[11:0];
                cm_data_ff <= hwdata[ebc_pkg::MEM_D_LSB +: 4];
                cm_wr_ff   <= hwdata[ebc_pkg::MEM_WR_BIT];
            end
            if (is_reg(addr_ff, ebc_pkg::OFS_CM_REG))
            begin
                cm_val_ff.a     <= hwdata[ebc_pkg::REG_A_LSB +: 4];
                cm_val_ff.b     <= hwdata[ebc_pkg::REG_B_LSB +: 4];
                cm_val_ff.flags <= hwdata[ebc_pkg::REG_F_LSB +: 4];
            end
            if (is_reg(addr_ff, ebc_pkg::OFS_CM_X))
            begin
                cm_val_ff.x <= hwdata[11:0];
            end
            if (is_reg(addr_ff, ebc_pkg::OFS_CM_Y))
            begin
                cm_val_ff.y <= hwdata[11:0];
            end
            if (is_reg(addr_ff, ebc_pkg::OFS_CM_MASK))
            begin
                cm_amsk_ff <= hwdata[3:0];
                cm_msk_ff  <= {hwdata[4], hwdata[5], hwdata[9:6], hwdata[10], hwdata[11]};
            end
        end
    end

    // Break mode lives apart so clear all cannot touch it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_ff <= ebc_pkg::RST_MODE;
        end
        else if (wr_go && is_reg(addr_ff, ebc_pkg::OFS_MODE))
        begin
            mode_ff[0] <= hwdata[ebc_pkg::MODE_EN];
        end
    end

    // ------------------------------------------------------------
    // Arming commands
    // ------------------------------------------------------------

    // Later statements win: cancels and clear all override arms
    // issued in the same write
    always_comb
    begin
        nxt_armed = armed_ff;
        if (wr_go && is_reg(addr_ff, ebc_pkg::OFS_CMD))
        begin
            if (hwdata[ebc_pkg::CMD_ARM_ADR])
            begin
                nxt_armed[ebc_pkg::ARM_ADR] = 1'b1;
                nxt_armed[ebc_pkg::ARM_CM]  = 1'b0;
            end
            if (hwdata[ebc_pkg::CMD_ARM_DAT])
            begin
                nxt_armed[ebc_pkg::ARM_DAT] = 1'b1;
                nxt_armed[ebc_pkg::ARM_CM]  = 1'b0;
            end
            if (hwdata[ebc_pkg::CMD_ARM_RM])
            begin
                nxt_armed[ebc_pkg::ARM_RM] = 1'b1;
                nxt_armed[ebc_pkg::ARM_CM] = 1'b0;
            end
            if (hwdata[ebc_pkg::CMD_ARM_CM])
            begin
                nxt_armed = 4'h0;
                nxt_armed[ebc_pkg::ARM_CM] = 1'b1;
            end
            if (hwdata[ebc_pkg::CMD_RM_CAN])
            begin
                nxt_armed[ebc_pkg::ARM_RM] = 1'b0;
            end
            if (hwdata[ebc_pkg::CMD_CM_CAN])
            begin
                nxt_armed[ebc_pkg::ARM_CM] = 1'b0;
            end
            if (hwdata[ebc_pkg::CMD_CLR_ALL])
            begin
                nxt_armed = ebc_pkg::RST_ARMED;
            end
        end
    end

    // Armed state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            armed_ff <= ebc_pkg::RST_ARMED;
        end
        else
        begin
            armed_ff <= nxt_armed;
        end
    end

    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------

    // Register match set
    ebc_regcmp u_rm_cmp
    (
        .obs   (cpu_obs.regs),
        .ref_v (rm_val_ff),
        .msk   (rm_msk_ff),
        .hit   (rm_hit)
    );

    // Register part of the compound condition
    ebc_regcmp u_cm_cmp
    (
        .obs   (cpu_obs.regs),
        .ref_v (cm_val_ff),
        .msk   (cm_msk_ff),
        .hit   (cm_reg_hit)
    );

    // Access part: direction, data nibble, address; the access
    // itself is demanded even with every field masked
    assign cm_acc_hit = cpu_obs.mem_acc
                      & (cm_amsk_ff[ebc_pkg::MSK_ADDR] | (cpu_obs.mem_addr == cm_addr_ff))
                      & (cm_amsk_ff[ebc_pkg::MSK_DATA] | (cpu_obs.mem_data == cm_data_ff))
                      & (cm_amsk_ff[ebc_pkg::MSK_RW]   | (cpu_obs.mem_wr == cm_wr_ff));
    assign cm_pc_hit  = cm_amsk_ff[ebc_pkg::MSK_PC] | (cpu_obs.pc == cm_pc_ff);

    // Events sampled on the last cycle of an instruction; the CPU
    // is only observed, so it never waits on the comparison
    assign ev[ebc_pkg::EV_RM] = cpu_obs.instr_end & armed_ff[ebc_pkg::ARM_RM] & rm_hit;
    assign ev[ebc_pkg::EV_CM] = cpu_obs.instr_end & armed_ff[ebc_pkg::ARM_CM]
                              & cm_pc_hit & cm_acc_hit & cm_reg_hit;

    // ------------------------------------------------------------
    // Halt and interrupt
    // ------------------------------------------------------------

    // Halt pulse the cycle after the matching instruction ends,
    // gated by the break enable mode
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            halt_ff <= 1'b0;
        end
        else
        begin
            halt_ff <= mode_ff[0] & (|ev);
        end
    end

    // Sticky events: a new event wins over a clear in the same cycle
    always_comb
    begin
        nxt_stat = stat_ff;
        if (wr_go && is_reg(addr_ff, ebc_pkg::OFS_IRQ_STAT))
        begin
            nxt_stat = stat_ff & ~hwdata[1:0];
        end
        nxt_stat = nxt_stat | ev;
    end

    // Status, mask and interrupt registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stat_ff <= 2'h0;
            mask_ff <= 2'h0;
            irq_ff  <= 1'b0;
        end
        else
        begin
            stat_ff <= nxt_stat;
            if (wr_go && is_reg(addr_ff, ebc_pkg::OFS_IRQ_MASK))
            begin
                mask_ff <= hwdata[1:0];
            end
            irq_ff <= |(nxt_stat & mask_ff);
        end
    end

    // ------------------------------------------------------------
    // Outputs, all but the constant hresp straight from flip-flops
    // ------------------------------------------------------------
    assign hreadyout = hreadyout_ff;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    assign halt_req  = halt_ff;
    assign armed     = armed_ff;
    assign irq       = irq_ff;

endmodule : ebc_break

// ===== ebc_break_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the break comparator
// ----------------------------------------
module ebc_break_assertions
(
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire logic                  hsel,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire ebc_pkg::ebc_cpu_obs_t cpu_obs,
    input wire logic                  halt_req,
    input wire logic [3:0]            armed
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Write taken; armed may only move two edges later
    wire logic wtk = hsel && hready && htrans[1] && hwrite;
    sequence s_rd; hsel && hready && htrans[1] && !hwrite; endsequence
    sequence s_wait; !hreadyout ##1 hreadyout; endsequence
    property p_rd_wait; s_rd |=> s_wait; endproperty
    property p_wr_fast; wtk |=> hreadyout; endproperty
    property p_one_wait; !hreadyout |=> hreadyout; endproperty
    property p_okay; hresp == 1'b0; endproperty
    property p_halt_end; halt_req |-> $past(cpu_obs.instr_end) && ($past(armed) != 4'h0); endproperty
    property p_cm_mem; halt_req && ($past(armed) == 4'h8) |-> $past(cpu_obs.mem_acc); endproperty
    property p_excl; !(armed[3] && (armed[2:0] != 3'h0)); endproperty
    property p_armed_cmd; !$past(wtk, 2) |-> $stable(armed); endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    a_one_wait: assert property (p_one_wait) else $error("ready low too long");
    a_okay: assert property (p_okay) else $error("response not okay");
    a_halt_end: assert property (p_halt_end) else $error("halt without armed instruction end");
    a_cm_mem: assert property (p_cm_mem) else $error("compound halt without memory access");
    a_excl: assert property (p_excl) else $error("compound armed with other classes");
    a_armed_cmd: assert property (p_armed_cmd) else $error("armed changed without command");
endmodule : ebc_break_assertions
bind ebc_break ebc_break_assertions ebc_break_assertions_inst (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .cpu_obs, .halt_req, .armed);

// ===== ebc_cpu_model.sv
`timescale 1ns/10ps
// Observed CPU: shows one instruction per step, else wandering fields
module ebc_cpu_model
(
    input  wire logic                  hclk,
    input  wire logic                  step,
    input  wire ebc_pkg::ebc_cpu_obs_t ins,
    output ebc_pkg::ebc_cpu_obs_t      obs
);
    initial obs = '0;
    // Idle fields toggle so stale values never pass for a valid instruction
    always @(posedge hclk)
        obs <= step ? ins : {1'b0, ~obs[$bits(obs)-2:0]};
endmodule : ebc_cpu_model

// ===== ebc_break_tb.sv
`timescale 1ns/10ps
module ebc_break_tb;
    logic hclk = 0, hresetn = 0, hwrite = 0, step = 0, hreadyout, hresp, halt_req, irq;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [31:0] hwdata = 0, hrdata, rd_q;
    logic [3:0] armed;
    ebc_pkg::ebc_cpu_obs_t ins = '0, obs, t;
    ebc_pkg::ebc_regset_t rv;
    logic [35:0] care = {8'hff, 4'h0, 24'hffffff}; // Flags masked out
    int err_total = 0, n_checks = 0;
    initial forever #25 hclk = ~hclk;
    ebc_cpu_model ebc_cpu_model_inst (.hclk, .step, .ins, .obs);
    ebc_break ebc_break_inst (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cpu_obs(obs), .halt_req, .armed, .irq);
    task automatic end_of_test;
        if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR at %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Ready sampled half a cycle before the edge it qualifies
    task automatic wait_rdy;
        int n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1)
        begin
            if (++n > 20) begin err_total++; end_of_test(); end
            @(negedge hclk);
        end
        rd_q = hrdata;
        @(posedge hclk);
    endtask : wait_rdy
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : xfer
    // One instruction, halt expected one cycle after its last cycle
    task automatic run(input logic e);
        @(posedge hclk);
        step <= 1'b1;
        ins <= t;
        @(posedge hclk);
        step <= 1'b0;
        @(posedge hclk);
        @(negedge hclk);
        chk(halt_req, e);
    endtask : run
    task automatic cm_try(input logic [11:0] pc, input logic acc, input logic e);
        t = $bits(t)'({$urandom, $urandom, $urandom});
        t.instr_end = 1'b1;
        t.pc = pc;
        t.mem_acc = acc;
        t.regs.x = 12'hfff;
        t.regs.y = 12'h03e;
        run(e);
    endtask : cm_try
    initial
    begin
        void'($urandom(32'h965fb14d));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(8'h04, 0, 0); chk(rd_q, 0);
        xfer(8'h3c, 0, 0); chk(rd_q, 0);
        rv = $bits(rv)'({$urandom, $urandom});
        rv.x = 12'hfff;
        xfer(8'h10, 1, {20'h0, rv.flags, rv.b, rv.a});
        xfer(8'h14, 1, {20'h0, rv.x});
        xfer(8'h18, 1, {20'h0, rv.y});
        xfer(8'h1c, 1, 32'h3c);
        xfer(8'h0c, 1, 32'h3);
        xfer(8'h00, 1, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            t = $bits(t)'({$urandom, $urandom, $urandom});
            t.instr_end = 1'b1;
            if (i % 2 == 0) t.regs = (t.regs & ~care) | (rv & care);
            run(((t.regs ^ rv) & care) == 36'h0);
        end
        chk(irq, 1);
        xfer(8'h0c, 1, 32'h2);
        xfer(8'h08, 0, 0); chk(rd_q, 1); chk(irq, 0);
        xfer(8'h08, 1, 32'h1);
        xfer(8'h08, 0, 0); chk(rd_q, 0);
        xfer(8'h00, 1, 32'h2); xfer(8'h04, 0, 0); chk(rd_q, 0);
        t.regs = rv; run(0);
        xfer(8'h00, 1, 32'h1);
        xfer(8'h20, 1, 32'h100); xfer(8'h2c, 1, 32'hfff); xfer(8'h30, 1, 32'h03e);
        xfer(8'h34, 1, 32'h3fe); xfer(8'h00, 1, 32'h4);
        xfer(8'h04, 0, 0); chk(rd_q, 8);
        cm_try(12'h100, 0, 0);
        cm_try(12'h100, 1, 1);
        cm_try(12'h101, 1, 0);
        xfer(8'h00, 1, 32'h60); xfer(8'h04, 0, 0); chk(rd_q, 3);
        xfer(8'h20, 1, 32'h101); xfer(8'h00, 1, 32'h4);
        cm_try(12'h100, 1, 0);
        cm_try(12'h101, 1, 1);
        xfer(8'h00, 1, 32'h8); xfer(8'h04, 0, 0); chk(rd_q, 0);
        xfer(8'h38, 1, 0); xfer(8'h00, 1, 32'h4); xfer(8'h00, 1, 32'h10); xfer(8'h04, 0, 0); chk(rd_q, 0);
        xfer(8'h38, 0, 0); chk(rd_q, 0);
        end_of_test();
    end
endmodule : ebc_break_tb
